// *** rtl/mbfp_pkg.sv ***
// package: constants and carrier types for the motor bridge fault protection block
package mbfp_pkg;

   // clock rate
   localparam int unsigned CLK_HZ             = 100_000_000;

   // times in their own units, as printed
   localparam int unsigned OT_MASK_NS         = 5000;   // over-temperature mask, 5.0 us
   localparam int unsigned OC_MASK_NS         = 1500;   // overcurrent mask, 1.5 us
   localparam int unsigned OC_RECOVERY_US     = 3000;   // overcurrent recovery, 3 ms
   localparam int unsigned BLANK_NS           = 3600;   // noise blanking, 3.6 us

   // cycle counts derived from the rate (mask and blanking are least times: round up)
   localparam int unsigned OT_MASK_CYC  = (OT_MASK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned OC_MASK_CYC  = (OC_MASK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned BLANK_CYC    = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned OC_RECOV_CYC = OC_RECOVERY_US * (CLK_HZ / 1_000_000);

   localparam int unsigned CNT_W        = 20;   // wide enough for the recovery count

   // drive pair from the controller, inputs a and b
   typedef struct packed {
      logic a;
      logic b;
   } mbfp_pair_t;

   // bridge leg states: high side on, low side on
   typedef struct packed {
      logic hs_a;
      logic ls_a;
      logic hs_b;
      logic ls_b;
   } mbfp_gate_t;

   // analog detector indications, all active high
   typedef struct packed {
      logic over_temp;     // above trip, stays until cooled below release
      logic supply_low;    // undervoltage comparator with hysteresis
      logic over_current;
      logic sense_short;
      logic sense_trip;    // chopping current comparison
   } mbfp_det_t;

   localparam mbfp_gate_t GATES_OFF = '{default: 1'b0};

endpackage

// *** rtl/mbfp_core.sv ***
// module: fault protection and drive decode for a single brushed motor H-bridge
//
// Behaviour
// - over-temperature trip turns every bridge transistor off
// - over-temperature indications shorter than the mask time are ignored
// - outputs resume by themselves once the over-temperature indication clears
// - while motor supply is low all bridge transistors are held off
// - lockout releases only when the hysteretic supply indication clears
// - overcurrent trip turns every bridge transistor off
// - overcurrent indications shorter than the mask time are ignored
// - after overcurrent, outputs stay off for the recovery time, then resume
// - sense-node short indication turns every bridge transistor off
// - chopping current comparison is ignored during the blanking time
// - both inputs low selects standby, outputs off
// - both inputs high selects brake
module mbfp_core
   import mbfp_pkg::*;
#(
   parameter int unsigned OC_RECOVERY_CYCLES = OC_RECOV_CYC
)(
   input  wire logic       clk_sys_i,
   input  wire logic       sys_rst_i,
   input  wire mbfp_pair_t drive_input_i,
   input  wire mbfp_det_t  detect_i,
   output mbfp_gate_t      bridge_gate_o,
   output logic            fault_off_o,
   output logic            chop_off_o
);

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   mbfp_pair_t drv_meta_reg;
   mbfp_pair_t drv_sync_reg;
   mbfp_det_t  det_meta_reg;
   mbfp_det_t  det_sync_reg;

   // pins and analog comparators are asynchronous: two flops each
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         drv_meta_reg <= '0;
         drv_sync_reg <= '0;
         det_meta_reg <= '0;
         det_sync_reg <= '0;
      end
      else
      begin
         drv_meta_reg <= drive_input_i;
         drv_sync_reg <= drv_meta_reg;
         det_meta_reg <= detect_i;
         det_sync_reg <= det_meta_reg;
      end
   end

   // ------------------------------------------------------------
   // helper
   // ------------------------------------------------------------
   // saturating count step used by every timer
   function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] lim);
      cnt_step = (c >= lim) ? lim : c + 1'b1;
   endfunction

   localparam logic [CNT_W-1:0] OT_LIM  = CNT_W'(OT_MASK_CYC);
   localparam logic [CNT_W-1:0] OC_LIM  = CNT_W'(OC_MASK_CYC);
   localparam logic [CNT_W-1:0] BLK_LIM = CNT_W'(BLANK_CYC);
   localparam logic [CNT_W-1:0] REC_LIM = CNT_W'(OC_RECOVERY_CYCLES);

   // ------------------------------------------------------------
   // over-temperature mask and latch
   // ------------------------------------------------------------
   logic [CNT_W-1:0] ot_cnt_reg;
   logic             ot_off_reg;

   // counter restarts on any gap, so short glitches never reach the limit
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         ot_cnt_reg <= '0;
      else if (!det_sync_reg.over_temp)
         ot_cnt_reg <= '0;
      else
         ot_cnt_reg <= cnt_step(ot_cnt_reg, OT_LIM);
   end

   // the detector itself carries the thermal hysteresis; release follows it
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
         ot_off_reg <= 1'b0;
      else if (!det_sync_reg.over_temp)
         ot_off_reg <= 1'b0;
      else if (ot_cnt_reg == OT_LIM - 1'b1)
         ot_off_reg <= 1'b1;
   end

   // ------------------------------------------------------------
   // overcurrent mask and recovery
   // ------------------------------------------------------------
   typedef enum logic [1:0] {OC_RUN, OC_RECOVER} mbfp_oc_state_t;
   mbfp_oc_state_t   oc_state_reg;
   logic [CNT_W-1:0] oc_cnt_reg;

   // one counter serves both the mask (in run) and the off time (in recover)
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         oc_state_reg <= OC_RUN;
         oc_cnt_reg   <= '0;
      end
      else
      begin
         case (oc_state_reg)
            OC_RUN:
            begin
               if (!det_sync_reg.over_current)
                  oc_cnt_reg <= '0;
               else if (oc_cnt_reg == OC_LIM - 1'b1)
               begin
                  oc_state_reg <= OC_RECOVER;
                  oc_cnt_reg   <= '0;
               end
               else
                  oc_cnt_reg <= cnt_step(oc_cnt_reg, OC_LIM);
            end
            OC_RECOVER:
            begin
               if (oc_cnt_reg == REC_LIM - 1'b1)
               begin
                  oc_state_reg <= OC_RUN;
                  oc_cnt_reg   <= '0;
               end
               else
                  oc_cnt_reg <= cnt_step(oc_cnt_reg, REC_LIM);
            end
            default:
            begin
               oc_state_reg <= OC_RUN;
               oc_cnt_reg   <= '0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // combined fault
   // ------------------------------------------------------------
   logic fault_any;

   // a fault holds off until each source has met its own release
   assign fault_any = ot_off_reg
                    | det_sync_reg.supply_low
                    | (oc_state_reg == OC_RECOVER)
                    | det_sync_reg.sense_short;

   // ------------------------------------------------------------
   // chopping blanking
   // ------------------------------------------------------------
   logic [CNT_W-1:0] blk_cnt_reg;
   logic             blk_active;
   mbfp_pair_t       drv_prev_reg;

   assign blk_active = (blk_cnt_reg < BLK_LIM);

   // blanking restarts whenever the drive pattern changes, covering switching spikes
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         blk_cnt_reg  <= '0;
         drv_prev_reg <= '0;
      end
      else
      begin
         drv_prev_reg <= drv_sync_reg;
         if (drv_sync_reg != drv_prev_reg)
            blk_cnt_reg <= '0;
         else
            blk_cnt_reg <= cnt_step(blk_cnt_reg, BLK_LIM);
      end
   end

   // ------------------------------------------------------------
   // drive decode and outputs
   // ------------------------------------------------------------
   mbfp_gate_t gate_next;

   // inputs are trusted to be steady for the minimum pulse width no filter here
   always_comb
   begin
      gate_next = GATES_OFF;
      case ({drv_sync_reg.a, drv_sync_reg.b})
         2'b10:   gate_next = '{hs_a: 1'b1, ls_a: 1'b0, hs_b: 1'b0, ls_b: 1'b1};
         2'b01:   gate_next = '{hs_a: 1'b0, ls_a: 1'b1, hs_b: 1'b1, ls_b: 1'b0};
         2'b11:   gate_next = '{hs_a: 1'b0, ls_a: 1'b1, hs_b: 1'b0, ls_b: 1'b1};
         default: gate_next = GATES_OFF;
      endcase
      if (fault_any)
         gate_next = GATES_OFF;
   end

   // registered outputs; chopping off only drops the high sides
   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         bridge_gate_o <= GATES_OFF;
         fault_off_o   <= 1'b0;
         chop_off_o    <= 1'b0;
      end
      else
      begin
         fault_off_o <= fault_any;
         chop_off_o  <= det_sync_reg.sense_trip & !blk_active;
         if (det_sync_reg.sense_trip && !blk_active && !fault_any)
         begin
            bridge_gate_o      <= gate_next;
            bridge_gate_o.hs_a <= 1'b0;
            bridge_gate_o.hs_b <= 1'b0;
         end
         else
            bridge_gate_o <= gate_next;
      end
   end

endmodule

// *** tb/mbfp_core_monitor.sv ***
// checker: timing relations of the fault protection core, bound to every instance
module mbfp_core_monitor
   import mbfp_pkg::*;
#(
   parameter int unsigned OC_RECOVERY_CYCLES = OC_RECOV_CYC
)(
   input wire logic       clk_sys_i,
   input wire logic       sys_rst_i,
   input wire mbfp_pair_t drive_input_i,
   input wire mbfp_det_t  detect_i,
   input wire mbfp_gate_t bridge_gate_o,
   input wire logic       fault_off_o,
   input wire logic       chop_off_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int         ot_n, oc_n, clr_n, chg_n, age;
   mbfp_pair_t drv_q;
   mbfp_gate_t dec;
   // run lengths restart at reset so a stale count never satisfies a check
   always_ff @(posedge clk_sys_i)
   begin
      ot_n  <= (sys_rst_i || !detect_i.over_temp) ? 0 : ot_n + 1;
      oc_n  <= (sys_rst_i || !detect_i.over_current) ? 0 : oc_n + 1;
      clr_n <= (sys_rst_i || detect_i[4:1] != 4'h0) ? 0 : clr_n + 1;
      chg_n <= (sys_rst_i || drive_input_i != drv_q) ? 0 : chg_n + 1;
      age   <= sys_rst_i ? 0 : ((age < 8) ? age + 1 : age);
      drv_q <= drive_input_i;
   end
   // expected decode; chopping removes only the high sides
   assign dec = {drive_input_i.a & ~drive_input_i.b & ~chop_off_o, drive_input_i.b,
                 drive_input_i.b & ~drive_input_i.a & ~chop_off_o, drive_input_i.a};
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   chk_gates_forced_off: assert property (fault_off_o |-> bridge_gate_o == GATES_OFF)
      else $error("gates on while fault forces off");
   chk_level_fault_trip: assert property ((detect_i.supply_low || detect_i.sense_short)[*3] |=> fault_off_o)
      else $error("supply or short fault not acted on");
   chk_mask_before_trip: assert property ($rose(fault_off_o) |-> ot_n >= 490 || oc_n >= 140
      || $past(detect_i.supply_low, 3) || $past(detect_i.sense_short, 3)) else $error("trip without cause");
   chk_temp_trip: assert property (ot_n == 510 |-> fault_off_o)
      else $error("long over-temperature not acted on");
   chk_current_trip: assert property (oc_n == 160 |-> fault_off_o)
      else $error("long overcurrent not acted on");
   chk_auto_release: assert property (clr_n == OC_RECOVERY_CYCLES + 10 |-> !fault_off_o)
      else $error("outputs not resumed after faults cleared");
   chk_drive_decode: assert property ($stable(drive_input_i)[*4] ##0 (age == 8 && !fault_off_o)
      |-> bridge_gate_o == dec) else $error("bridge gates do not match drive inputs");
   chk_chop_blanked: assert property ($rose(chop_off_o) |-> chg_n >= 355)
      else $error("chopping trip inside blanking time");
   cover property ($rose(fault_off_o));
   cover property ($fell(fault_off_o));
   cover property ($rose(chop_off_o));
endmodule
bind mbfp_core mbfp_core_monitor #(.OC_RECOVERY_CYCLES(OC_RECOVERY_CYCLES)) u_mon (.clk_sys_i(clk_sys_i),
   .sys_rst_i(sys_rst_i), .drive_input_i(drive_input_i), .detect_i(detect_i), .bridge_gate_o(bridge_gate_o),
   .fault_off_o(fault_off_o), .chop_off_o(chop_off_o));

// *** tb/mbfp_ctrl_model.sv ***
// controller model: follows commanded drive levels, never shorter than the least hold
module mbfp_ctrl_model
   import mbfp_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire mbfp_pair_t cmd_i,
   output mbfp_pair_t      drive_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int held = 0;
   initial drive_o = '0;
   // a command waits until the level has stood 51 cycles; a short one that reverts sooner is lost
   always @(negedge clk_sys_i)
   begin
      if (cmd_i != drive_o && held >= 50)
      begin
         drive_o <= cmd_i;
         held    <= 0;
      end
      else
         held <= held + 1;
   end
endmodule

// *** tb/mbfp_core_test.sv ***
// testbench: scenario tasks for the fault protection core
module mbfp_core_test
   import mbfp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RECOV = 200;
   logic       clk_sys_i = 1'b0;
   logic       sys_rst_i = 1'b1;
   mbfp_pair_t cmd = '0;
   mbfp_pair_t drive;
   mbfp_det_t  det = '0;
   mbfp_gate_t gate;
   logic       fault_off, chop_off;
   int         failures = 0, checked = 0, n;
   always #5 clk_sys_i = ~clk_sys_i;
   mbfp_ctrl_model ctrl (.clk_sys_i(clk_sys_i), .cmd_i(cmd), .drive_o(drive));
   mbfp_core #(.OC_RECOVERY_CYCLES(RECOV)) dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .drive_input_i(drive),
      .detect_i(det), .bridge_gate_o(gate), .fault_off_o(fault_off), .chop_off_o(chop_off));
   task cyc(input int k);
      repeat (k) @(negedge clk_sys_i);
   endtask
   task chk(input string what, input logic [3:0] exp, input logic [3:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask
   task end_sim;
      if (failures == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // forward, reverse, brake, standby in turn
   task t_decode;
      mbfp_pair_t code [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
      logic [3:0] expg [4] = '{4'h9, 4'h6, 4'h5, 4'h0};
      for (int i = 0; i < 4; i++)
      begin
         cmd <= code[i];
         cyc(60);
         chk("gate", expg[i], gate);
      end
   endtask
   // supply low, then sense short: off within the sync delay, back on when cleared
   task t_level;
      for (int i = 0; i < 2; i++)
      begin
         det[3 - 2 * i] = 1'b1;
         cyc(4);
         chk("gate", 4'h0, gate);
         det[3 - 2 * i] = 1'b0;
         cyc(4);
         chk("gate", 4'h9, gate);
      end
   endtask
   // a pulse shorter than the mask is ignored, a longer one trips
   task t_temp;
      det.over_temp = 1'b1;
      cyc(300);
      det.over_temp = 1'b0;
      cyc(10);
      chk("fault", 4'h0, 4'(fault_off));
      // the gap must restart the mask: 300 + 400 cycles would trip a counter that only pauses
      det.over_temp = 1'b1;
      cyc(400);
      chk("fault", 4'h0, 4'(fault_off));
      cyc(110);
      chk("fault", 4'h1, 4'(fault_off));
      det.over_temp = 1'b0;
      cyc(5);
      chk("gate", 4'h9, gate);
   endtask
   task t_current;
      det.over_current = 1'b1;
      cyc(100);
      chk("fault", 4'h0, 4'(fault_off));
      det.over_current = 1'b0;
      cyc(10);
      det.over_current = 1'b1;
      cyc(160);
      chk("fault", 4'h1, 4'(fault_off));
      det.over_current = 1'b0;
      for (n = 0; fault_off === 1'b1 && n < 1000; n++) cyc(1);
      checked++;
      if (n < RECOV - 15 || n > RECOV)
      begin
         $display("MISMATCH recovery expected %0d seen %0d", RECOV, n);
         failures++;
      end
      chk("gate", 4'h9, gate);
   endtask
   // two faults at once: off until the last one releases
   task t_multi;
      det.supply_low = 1'b1;
      det.over_temp  = 1'b1;
      cyc(520);
      det.supply_low = 1'b0;
      cyc(5);
      chk("fault", 4'h1, 4'(fault_off));
      det.over_temp = 1'b0;
      cyc(5);
      chk("gate", 4'h9, gate);
   endtask
   // chopping trip ignored until the blanking time after a drive change
   task t_chop;
      cmd <= 2'h0;
      cyc(60);
      cmd <= 2'h2;
      det.sense_trip = 1'b1;
      cyc(300);
      chk("gate", 4'h9, gate);
      chk("chop", 4'h0, 4'(chop_off));
      cyc(80);
      chk("gate", 4'h1, gate);
      chk("chop", 4'h1, 4'(chop_off));
      det.sense_trip = 1'b0;
   endtask
   // reset in mid-run clears every output; a standing supply fault is taken up again after it
   task t_reset;
      det.supply_low = 1'b1;
      cyc(4);
      chk("fault", 4'h1, 4'(fault_off));
      sys_rst_i = 1'b1;
      cyc(2);
      chk("gate", 4'h0, gate);
      chk("fault", 4'h0, 4'(fault_off));
      sys_rst_i = 1'b0;
      cyc(1);
      chk("fault", 4'h0, 4'(fault_off));
      cyc(3);
      chk("fault", 4'h1, 4'(fault_off));
      det.supply_low = 1'b0;
      cyc(4);
      chk("gate", 4'h9, gate);
   endtask
   initial
   begin
      cyc(2);
      sys_rst_i = 1'b0;
      t_decode;
      cmd <= 2'h2;
      cyc(60);
      t_level;
      t_temp;
      t_current;
      t_multi;
      t_chop;
      t_reset;
      end_sim;
   end
   // whole run is about 2600 cycles; cut a hang well past that
   initial
   begin
      #100_000;
      failures++;
      end_sim;
   end
endmodule
